// ### src/tbk_pkg.sv
// constants shared by the front-panel interrupt and tone logic
package tbk_pkg;
    localparam logic [7:0]  OPC_RESTART   = 8'hff;
    localparam logic [7:0]  OPC_INT_ON    = 8'hfb;
    localparam logic [7:0]  OPC_HALT      = 8'h76;
    localparam logic [15:0] RESTART_ADDR  = 16'h0038;
    localparam logic [15:0] STOP_VEC_ADDR = 16'h0066;
    localparam logic [15:0] TGT_LO_ADDR   = 16'h1fee;
    localparam logic [15:0] TGT_HI_ADDR   = 16'h1fef;
    localparam logic [7:0]  TGT_LO_INIT   = 8'h66;
    localparam logic [7:0]  TGT_HI_INIT   = 8'h00;
    localparam logic [15:0] STACK_INIT    = 16'h1f9f;
    localparam logic [7:0]  IEL_SET_VIEW  = 8'h01;
    localparam logic [7:0]  IEL_CLR_VIEW  = 8'h00;
    localparam logic [7:0]  PITCH_2K      = 8'h1f;
    localparam logic [15:0] TONE_BASE     = 16'h002c;
    localparam logic [15:0] TONE_STEP     = 16'h000d;
    localparam logic [15:0] ONE16         = 16'h0001;
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          DEBOUNCE_NS   = 10_000_000;
    localparam int          DEBOUNCE_CYC  = DEBOUNCE_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TBK_IDLE,
        TBK_RESTART,
        TBK_INDIRECT,
        TBK_STOP
    } tbk_seq_t;

    // half period of the tone in clocks: 44 + 13 * pitch
    function automatic logic [15:0] tbk_half_cycles(input logic [7:0] p);
        tbk_half_cycles = TONE_BASE + 16'(TONE_STEP * {8'h00, p});
    endfunction
endpackage

// ### src/tbk_debounce.sv
// key synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ps
`default_nettype none
module tbk_debounce #(
    parameter int DEB_CYC = 200000
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic key_n,
    output var  logic press_r
);
    logic        meta_r;
    logic        sync_r;
    logic        level_r;
    logic [31:0] cnt_r;
    wire         differs = sync_r != level_r;
    wire         settled = cnt_r >= 32'(DEB_CYC - 1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r  <= 1'b1;
            sync_r  <= 1'b1;
            level_r <= 1'b1;
            cnt_r   <= '0;
            press_r <= 1'b0;
        end else begin
            meta_r  <= key_n;
            sync_r  <= meta_r;
            cnt_r   <= (differs && !settled) ? cnt_r + 32'd1 : '0;
            press_r <= differs && settled && level_r;
            if (differs && settled) begin
                level_r <= sync_r;
            end
        end
    end
endmodule
`default_nettype wire

// ### src/tbk_top.sv
// front-panel interrupt keys, halt recovery and tone generator
`timescale 1ns/1ps
`default_nettype none
module tbk_top
    import tbk_pkg::*;
#(
    parameter int DEB_CYC = DEBOUNCE_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        user_key_n,
    input  wire logic        stop_key_n,
    input  wire logic        resume_key,
    input  wire logic        insn_boundary,
    input  wire logic        opcode_valid,
    input  wire logic [7:0]  opcode,
    input  wire logic [15:0] insn_pc,
    input  wire logic [15:0] next_pc,
    input  wire logic        ram_wr,
    input  wire logic [15:0] ram_addr,
    input  wire logic [7:0]  ram_wdata,
    input  wire logic        panel_iel_wr,
    input  wire logic [7:0]  panel_iel_data,
    input  wire logic        panel_ivec_wr,
    input  wire logic [7:0]  panel_ivec_data,
    input  wire logic        tone_start,
    input  wire logic [15:0] tone_duration,
    input  wire logic        pitch_wr,
    input  wire logic [7:0]  pitch_data,
    output var  logic        int_req_r,
    output var  logic        nmi_req_r,
    output var  logic        redirect_r,
    output var  logic [15:0] redirect_addr_r,
    output var  logic [15:0] saved_pc_r,
    output var  logic        resumable_r,
    output var  logic        halt_led_r,
    output var  logic [15:0] stack_pointer_r,
    output var  logic [15:0] panel_view_r,
    output var  logic        speaker_r,
    output var  logic        tone_busy_r
);
    ////////////////////////////////////////////////////////////////////////
    logic        user_press;
    logic        stop_press;
    logic        iel_r;
    logic [7:0]  ivec_r;
    logic [7:0]  tgt_lo_r;
    logic [7:0]  tgt_hi_r;
    logic [15:0] halt_pc_r;
    tbk_seq_t    seq_r;
    logic [7:0]  pitch_r;
    logic [15:0] half_cnt_r;
    logic [15:0] duration_register_pair_r;

    tbk_debounce #(.DEB_CYC(DEB_CYC)) u_user_deb (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .key_n   (user_key_n),
        .press_r (user_press)
    );
    tbk_debounce #(.DEB_CYC(DEB_CYC)) u_stop_deb (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .key_n   (stop_key_n),
        .press_r (stop_press)
    );

    ////////////////////////////////////////////////////////////////////////
    // maskable path; a halted core takes no maskable request
    wire halted_now = halt_led_r;
    wire accept    = insn_boundary && int_req_r && iel_r && !halted_now
                     && seq_r == TBK_IDLE && !stop_press;
    wire en_op     = opcode_valid && opcode == OPC_INT_ON;
    wire iel_set   = en_op || (panel_iel_wr && panel_iel_data[0]);
    wire iel_clr   = accept || (panel_iel_wr && !panel_iel_data[0]);
    wire halt_exec = opcode_valid && opcode == OPC_HALT;
    wire [15:0] tgt_addr = {tgt_hi_r, tgt_lo_r};
    wire [7:0]  iel_view = iel_r ? IEL_SET_VIEW : IEL_CLR_VIEW;
    wire [15:0] stop_pc  = halted_now ? halt_pc_r + ONE16 : next_pc;
    wire [15:0] half_top = tbk_half_cycles(pitch_r) - ONE16;
    // >= so a pitch lowered mid-period cannot run the count past top
    wire        half_end = half_cnt_r >= half_top;
    wire        tone_last = half_end && duration_register_pair_r == ONE16;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_req_r <= 1'b0;
            iel_r     <= 1'b0;
            ivec_r    <= '0;
        end else begin
            // press while latch clear is simply dropped
            if (accept) begin
                int_req_r <= 1'b0;
            end else if (user_press && iel_r) begin
                int_req_r <= 1'b1;
            end else if (!iel_r) begin
                int_req_r <= 1'b0;
            end
            // a set in the acknowledge cycle wins so no enable is lost
            if (iel_set) begin
                iel_r <= 1'b1;
            end else if (iel_clr) begin
                iel_r <= 1'b0;
            end
            if (panel_ivec_wr) begin
                ivec_r <= panel_ivec_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indirect target mirror, stack pointer and panel view
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgt_lo_r        <= TGT_LO_INIT;
            tgt_hi_r        <= TGT_HI_INIT;
            stack_pointer_r <= STACK_INIT;
            panel_view_r    <= '0;
        end else begin
            if (ram_wr && ram_addr == TGT_LO_ADDR) begin
                tgt_lo_r <= ram_wdata;
            end
            if (ram_wr && ram_addr == TGT_HI_ADDR) begin
                tgt_hi_r <= ram_wdata;
            end
            panel_view_r <= {ivec_r, iel_view};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // redirect sequencer: restart, then indirect target; stop wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_r           <= TBK_IDLE;
            redirect_r      <= 1'b0;
            redirect_addr_r <= '0;
            nmi_req_r       <= 1'b0;
            saved_pc_r      <= '0;
            resumable_r     <= 1'b0;
            halt_led_r      <= 1'b0;
            halt_pc_r       <= '0;
        end else begin
            redirect_r <= 1'b0;
            nmi_req_r  <= stop_press;
            if (stop_press) begin
                saved_pc_r  <= stop_pc;
                resumable_r <= 1'b1;
                halt_led_r  <= 1'b0;
                redirect_r      <= 1'b1;
                redirect_addr_r <= STOP_VEC_ADDR;
                seq_r           <= TBK_STOP;
            end else begin
                if (halt_exec) begin
                    halt_led_r <= 1'b1;
                    halt_pc_r  <= insn_pc;
                end
                unique case (seq_r)
                    TBK_IDLE: begin
                        if (accept) begin
                            saved_pc_r      <= next_pc;
                            resumable_r     <= 1'b1;
                            redirect_r      <= 1'b1;
                            redirect_addr_r <= RESTART_ADDR;
                            seq_r           <= TBK_RESTART;
                        end else if (resume_key && resumable_r) begin
                            redirect_r      <= 1'b1;
                            redirect_addr_r <= saved_pc_r;
                        end
                    end
                    TBK_RESTART: begin
                        redirect_r      <= 1'b1;
                        redirect_addr_r <= tgt_addr;
                        seq_r           <= TBK_INDIRECT;
                    end
                    TBK_INDIRECT: begin
                        seq_r <= TBK_IDLE;
                    end
                    TBK_STOP: begin
                        seq_r <= TBK_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tone: one toggle per half period, duration counts toggles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tone_busy_r              <= 1'b0;
            speaker_r                <= 1'b0;
            pitch_r                  <= PITCH_2K;
            half_cnt_r               <= '0;
            duration_register_pair_r <= '0;
        end else if (tone_start) begin
            tone_busy_r              <= 1'b1;
            pitch_r                  <= PITCH_2K;
            half_cnt_r               <= '0;
            duration_register_pair_r <= tone_duration;
        end else if (tone_busy_r) begin
            if (pitch_wr) begin
                pitch_r <= pitch_data;
            end
            half_cnt_r <= half_end ? '0 : half_cnt_r + ONE16;
            if (half_end) begin
                speaker_r <= !speaker_r;
                // zero wraps first, giving 65536 half periods
                duration_register_pair_r <=
                    duration_register_pair_r - ONE16;
                tone_busy_r <= !tone_last;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_masked_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!iel_r && !int_req_r) |=> !int_req_r)
        else $error("request raised with latch clear");
    a_restart_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        accept |=> redirect_r && redirect_addr_r == RESTART_ADDR)
        else $error("restart address wrong");
    a_indirect_tgt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        accept ##1 !stop_press |=> redirect_r
            && redirect_addr_r == {$past(tgt_hi_r), $past(tgt_lo_r)})
        else $error("indirect target wrong");
    a_ack_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (accept && !iel_set) |=> !iel_r && !int_req_r)
        else $error("acknowledge did not clear latch");
    a_enable_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        en_op |=> iel_r)
        else $error("enable opcode did not set latch");
    a_stop_any: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stop_press |=> nmi_req_r && redirect_addr_r == STOP_VEC_ADDR)
        else $error("stop key not taken");
    a_halt_led: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (halt_exec && !stop_press) |=> halt_led_r ##1 (halt_led_r
            || $past(stop_press)))
        else $error("halt indicator wrong");
    a_halt_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (stop_press && halt_led_r) |=> !halt_led_r
            && saved_pc_r == $past(halt_pc_r) + ONE16)
        else $error("halt exit pc wrong");
    a_tone_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tone_busy_r && !tone_start && half_end)
            |=> speaker_r != $past(speaker_r) && half_cnt_r == '0)
        else $error("speaker toggle timing wrong");
    a_tone_pitch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tone_start |=> tone_busy_r && pitch_r == PITCH_2K)
        else $error("tone pitch not loaded");
endmodule
`default_nettype wire

// ### testbench/tbk_core_model.sv
// behavioural core model: boundaries, executed opcodes, ram writes
`timescale 1ns/1ps
`default_nettype none
module tbk_core_model (
    input  wire logic        sys_clk,
    input  wire logic        run,
    input  wire logic        redirect_r,
    input  wire logic [15:0] redirect_addr_r,
    output var  logic        insn_boundary,
    output var  logic        opcode_valid,
    output var  logic [7:0]  opcode,
    output var  logic [15:0] insn_pc,
    output var  logic [15:0] next_pc,
    output var  logic        ram_wr,
    output var  logic [15:0] ram_addr,
    output var  logic [7:0]  ram_wdata
);
    logic [1:0] ph_r;
    initial begin
        {insn_boundary, opcode_valid, ram_wr, ph_r} = '0;
        {opcode, insn_pc, ram_addr, ram_wdata} = '0;
        next_pc = 16'h1800;
    end
    // a boundary every fourth clock; a jump from the block wins
    always @(posedge sys_clk) begin
        #1;
        ph_r = ph_r + 2'h1;
        insn_boundary = run && ph_r == 2'h0;
        if (redirect_r)
            next_pc = redirect_addr_r;
        else if (insn_boundary)
            next_pc = next_pc + 16'h0001;
    end
    // qualifiers go stale once the strobe drops, so show inverted data
    task automatic exec(input logic [7:0] op, input logic [15:0] pc);
        @(posedge sys_clk);
        #1;
        opcode_valid = 1'b1;
        opcode = op;
        insn_pc = pc;
        next_pc = pc + 16'h0001;
        @(posedge sys_clk);
        #1;
        opcode_valid = 1'b0;
        opcode = ~op;
        insn_pc = ~pc;
    endtask
    task automatic ram_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        ram_wr = 1'b1;
        ram_addr = a;
        ram_wdata = d;
        @(posedge sys_clk);
        #1;
        ram_wr = 1'b0;
        ram_addr = ~a;
        ram_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the panel interrupt keys and tone logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tbk_pkg::*;
    logic        sys_clk, rst_n, user_key_n, stop_key_n, resume_key, run;
    logic        panel_iel_wr, panel_ivec_wr, tone_start, pitch_wr;
    logic [7:0]  panel_iel_data, panel_ivec_data, pitch_data;
    logic [15:0] tone_duration, exp_pc;
    logic        insn_boundary, opcode_valid, ram_wr;
    logic [7:0]  opcode, ram_wdata;
    logic [15:0] insn_pc, next_pc, ram_addr;
    logic        int_req_r, nmi_req_r, redirect_r, resumable_r;
    logic        halt_led_r, speaker_r, tone_busy_r;
    logic [15:0] redirect_addr_r, saved_pc_r, stack_pointer_r, panel_view_r;
    int          n_errors, cmp_count, n;
    tbk_top #(.DEB_CYC(4)) dut_u (.sys_clk, .rst_n, .user_key_n, .stop_key_n,
        .resume_key, .insn_boundary, .opcode_valid, .opcode, .insn_pc,
        .next_pc, .ram_wr, .ram_addr, .ram_wdata, .panel_iel_wr,
        .panel_iel_data, .panel_ivec_wr, .panel_ivec_data, .tone_start,
        .tone_duration, .pitch_wr, .pitch_data, .int_req_r, .nmi_req_r,
        .redirect_r, .redirect_addr_r, .saved_pc_r, .resumable_r,
        .halt_led_r, .stack_pointer_r, .panel_view_r, .speaker_r,
        .tone_busy_r);
    tbk_core_model core_u (.sys_clk, .run, .redirect_r, .redirect_addr_r,
        .insn_boundary, .opcode_valid, .opcode, .insn_pc, .next_pc, .ram_wr,
        .ram_addr, .ram_wdata);
    always #25 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h", $time, m, got);
        end
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? int_req_r : k == 1 ? nmi_req_r : redirect_r;
    endfunction
    // bounded wait; running out ends the run as a failure
    task automatic wait_on(input int k);
        for (int i = 0; i < 60; i++) begin
            if (pick(k) === 1'b1)
                return;
            tick();
        end
        n_errors++;
        $display("wrong value at %0t: timeout %0d", $time, k);
        stop_test();
    endtask
    task automatic toggle_wait();
        logic s;
        s = speaker_r;
        for (n = 1; n < 1000; n++) begin
            tick();
            if (speaker_r !== s)
                return;
        end
        chk(16'h0, 16'h1, "no toggle");
    endtask
    task automatic panel(input logic [7:0] iel);
        panel_iel_wr = 1'b1;
        panel_iel_data = iel;
        panel_ivec_wr = 1'b1;
        tick();
        panel_iel_wr = 1'b0;
        panel_ivec_wr = 1'b0;
        tick();
    endtask
    task automatic user_press_ignored();
        user_key_n = 1'b0;
        repeat (20) tick();
        chk({15'h0, int_req_r}, 16'h0, "masked press");
        user_key_n = 1'b1;
        repeat (12) tick();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_user(input logic [15:0] tgt);
        user_key_n = 1'b0;
        wait_on(0);
        wait_on(2);
        chk(redirect_addr_r, RESTART_ADDR, "restart");
        tick();
        chk({15'h0, redirect_r}, 16'h1, "second jump");
        chk(redirect_addr_r, tgt, "target");
        repeat (2) tick();
        chk(panel_view_r, {8'h5a, IEL_CLR_VIEW}, "ack view");
        user_key_n = 1'b1;
        repeat (12) tick();
        user_press_ignored();
    endtask
    task automatic t_stop();
        run = 1'b0;
        repeat (3) tick();
        exp_pc = next_pc;
        stop_key_n = 1'b0;
        wait_on(1);
        chk(redirect_addr_r, STOP_VEC_ADDR, "stop vector");
        chk(saved_pc_r, exp_pc, "saved pc");
        chk({15'h0, resumable_r}, 16'h1, "resumable");
        stop_key_n = 1'b1;
        repeat (12) tick();
        resume_key = 1'b1;
        tick();
        resume_key = 1'b0;
        wait_on(2);
        chk(redirect_addr_r, exp_pc, "resume");
    endtask
    task automatic t_halt();
        panel(8'h01);
        core_u.exec(OPC_HALT, 16'h1803);
        tick();
        chk({15'h0, halt_led_r}, 16'h1, "halt led");
        run = 1'b1;
        user_key_n = 1'b0;
        repeat (20) tick();
        chk({15'h0, halt_led_r}, 16'h1, "still halted");
        run = 1'b0;
        stop_key_n = 1'b0;
        wait_on(1);
        chk({15'h0, halt_led_r}, 16'h0, "halt ends");
        chk(saved_pc_r, 16'h1804, "halt pc+1");
        {stop_key_n, user_key_n} = 2'b11;
        repeat (12) tick();
        panel(8'h00);
        chk(panel_view_r, {8'h5a, IEL_CLR_VIEW}, "panel clear");
        chk({15'h0, int_req_r}, 16'h0, "request dropped");
    endtask
    task automatic t_tone();
        tone_duration = 16'h0003;
        tone_start = 1'b1;
        tick();
        tone_start = 1'b0;
        toggle_wait();
        toggle_wait();
        chk(16'(n), 16'(int'(TONE_BASE) + int'(TONE_STEP) * int'(PITCH_2K)),
            "half period");
        chk({15'h0, tone_busy_r}, 16'h1, "busy");
        toggle_wait();
        chk({15'h0, tone_busy_r}, 16'h0, "tone end");
    endtask
    // start count zero wraps first, so three toggles leave it busy
    task automatic t_tone_long();
        tone_duration = 16'h0000;
        tone_start = 1'b1;
        tick();
        tone_start = 1'b0;
        pitch_wr = 1'b1;
        pitch_data = 8'h0f;
        tick();
        pitch_wr = 1'b0;
        toggle_wait();
        toggle_wait();
        chk(16'(n), 16'(int'(TONE_BASE) + int'(TONE_STEP) * int'(pitch_data)),
            "new pitch");
        toggle_wait();
        chk({15'h0, tone_busy_r}, 16'h1, "longest");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_clk, rst_n, resume_key, run, tone_start, pitch_wr} = '0;
        {user_key_n, stop_key_n} = 2'b11;
        {panel_iel_wr, panel_ivec_wr, panel_iel_data, pitch_data} = '0;
        panel_ivec_data = 8'h5a;
        tone_duration = 16'h0000;
        {n_errors, cmp_count} = '0;
        repeat (5) tick();
        rst_n = 1'b1;
        run = 1'b1;
        chk(stack_pointer_r, STACK_INIT, "sp");
        chk(panel_view_r, 16'h0000, "reset view");
        user_press_ignored();
        panel(8'h01);
        tick();
        chk(panel_view_r, {8'h5a, IEL_SET_VIEW}, "panel set");
        t_user({TGT_HI_INIT, TGT_LO_INIT});
        core_u.ram_write(TGT_LO_ADDR, 8'h00);
        core_u.ram_write(TGT_HI_ADDR, 8'h19);
        run = 1'b0;
        core_u.exec(OPC_INT_ON, 16'h1800);
        run = 1'b1;
        t_user(16'h1900);
        t_stop();
        t_halt();
        rst_n = 1'b0;
        tick();
        rst_n = 1'b1;
        chk({15'h0, resumable_r}, 16'h0, "no resume");
        chk(stack_pointer_r, STACK_INIT, "sp again");
        t_tone();
        t_tone_long();
        stop_test();
    end
endmodule
`default_nettype wire
